/* hw/tpam_map.svh */
// Register offsets, reset values and field positions of the port alert mask and control bank.
`ifndef TPAM_MAP_SVH
`define TPAM_MAP_SVH
`define TPAM_OFF_ALERT_LO     8'h10
`define TPAM_OFF_ALERT_HI     8'h11
`define TPAM_OFF_MASK_LO      8'h12
`define TPAM_OFF_MASK_HI      8'h13
`define TPAM_OFF_PWR_MASK     8'h14
`define TPAM_OFF_FLT_MASK     8'h15
`define TPAM_OFF_PORT_CTL     8'h19
`define TPAM_OFF_ROLE_CTL     8'h1a
`define TPAM_OFF_FLT_CTL      8'h1b
`define TPAM_OFF_PWR_CTL      8'h1c
`define TPAM_OFF_OVP_LEVEL    8'hcc
`define TPAM_OFF_OVP_STAT     8'hcd
`define TPAM_RST_MASK_LO      8'hff
`define TPAM_RST_MASK_HI      8'h0f
`define TPAM_RST_PWR_MASK     8'hff
`define TPAM_RST_FLT_MASK     8'hff
`define TPAM_RST_PORT_CTL     8'h00
`define TPAM_RST_ROLE_CTL     8'h0a
`define TPAM_RST_FLT_CTL      8'h00
`define TPAM_RST_PWR_CTL      8'h60
`define TPAM_RST_OVP_LEVEL    8'hff
`define TPAM_RST_ALERT        8'h02
`define TPAM_WMASK_MASK_HI    8'h8f
`define TPAM_WMASK_PORT_CTL   8'h33
`define TPAM_WMASK_ROLE_CTL   8'h7f
`define TPAM_WMASK_FLT_CTL    8'h1f
`define TPAM_WMASK_PWR_CTL    8'h7d
`define TPAM_BIT_ORIENT       0
`define TPAM_BIT_TEST         1
`define TPAM_BIT_DBG_OWNER    4
`define TPAM_BIT_WDOG         5
`define TPAM_BIT_DRP          6
`define TPAM_BIT_VCONN_OC_DIS 0
`define TPAM_BIT_DISC_TMR_OFF 3
`define TPAM_BIT_VCONN_EN     0
`define TPAM_BIT_OVP_FLAG     1
`define TPAM_BIT_SUM          1
`define TPAM_TERM_RA          2'h0
`define TPAM_TERM_RP          2'h1
`define TPAM_TERM_RD          2'h2
`define TPAM_TERM_OPEN        2'h3
`define TPAM_RP_RESERVED      2'h3
`endif

/* hw/tpam_pkg.sv */
// Types shared by the port alert mask and control bank.
package tpam_pkg;
    typedef enum logic [1:0] {
        TPAM_TGL_IDLE   = 2'b00,
        TPAM_TGL_PHASE  = 2'b01,
        TPAM_TGL_SETTLE = 2'b10
    } tpam_tgl_t;
endpackage

/* hw/tpam_regs.sv */
// Alert mask, power-status mask, fault mask and port control register bank.
`timescale 1ns/1ns
`default_nettype none
`include "tpam_map.svh"

// Summary of operation
// RULE1: Mask bit zero blocks its event from interrupt; one lets it through.
// RULE2: A masked event never pulls the interrupt low, though it stays recorded.
// RULE3: Second alert mask resets to 0x0f; bits 6:4 reserved.
// RULE4: Power-status mask resets to 0xff with eight mask bits.
// RULE5: Fault mask resets to 0xff with eight fault mask bits.
// RULE6: Port control bit 5 enables watchdog monitoring; reset disabled.
// RULE7: Bit 4 zero lets device drive debug flag; one hands it to host. Code holds the flag at its last value when bit 4 is one.
// RULE8: Serial clock is never stretched; stretch field has no effect.
// RULE9: Test bit set: received messages acknowledged but not reported as alert.
// RULE10: Host sets test bit only during compliance testing, clears on detach.
// RULE11: Orientation zero: VCONN to CC2, receive CC1; one swaps them.
// RULE12: Dual-role set: toggle terminations after seek command until attach.
// RULE13: Dual-role clear: terminations follow role fields, no toggling.
// RULE14: Pull-up current field: default, 1.5 A, 3 A; 11b reserved; resets 00b.
// RULE15: CC fields: Ra, Rp, Rd, open; both reset Rd, register 0x0a.
// RULE16: Fault control bit 3 one disables both discharge-failure timers.
// RULE17: Fault control bit 0 one disables VCONN overcurrent detection.
// RULE18: Forced-off and VBUS overcurrent control bits change no behaviour.
// RULE19: VBUS above level at 0xcc sets bit 1 at 0xcd and drives fault pin.
// RULE20: Interrupt low while any unmasked event is set; high otherwise.
// RULE21: Event bits stay set until host writes one to clear them.
// RULE22: Interrupt is inverted OR of event bits ANDed with mask bits.
// RULE23: Reserved bits read zero and ignore writes.
module tpam_regs #(
    parameter int TOGGLE_CYCLES = 1000
) (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       wr_en_in,
    input  wire logic       rd_en_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] rdata_out,
    input  wire logic [7:0] alert_lo_in,
    input  wire logic [7:0] alert_hi_in,
    input  wire logic [7:0] pwr_status_in,
    input  wire logic [7:0] fault_status_in,
    input  wire logic       rx_msg_in,
    input  wire logic       seek_attach_command_in,
    input  wire logic       attach_seen_in,
    input  wire logic       attach_as_sink_in,
    input  wire logic       dbg_accessory_dev_in,
    input  wire logic [7:0] vbus_level_in,
    output logic            irq_n_out,
    output logic [7:0]      alert_lo_event_out,
    output logic [7:0]      alert_hi_event_out,
    output logic            rx_msg_report_out,
    output logic            goodcrc_ack_out,
    output logic            watchdog_en_out,
    output logic            dbg_accessory_flag_out,
    output logic            vconn_cc1_out,
    output logic            vconn_cc2_out,
    output logic            rx_on_cc2_out,
    output logic [1:0]      cc1_term_out,
    output logic [1:0]      cc2_term_out,
    output logic [1:0]      pullup_current_level_out,
    output logic            seek_active_out,
    output logic            discharge_fail_timer_en_out,
    output logic            vconn_oc_detect_en_out,
    output logic            fault_pin_out,
    output logic            scl_hold_out
);
    if (TOGGLE_CYCLES < 1 || TOGGLE_CYCLES > 65535) begin : g_bad_toggle
        $error("TOGGLE_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file.
    logic [7:0] alert_mask_low_r;
    logic [7:0] alert_mask_high_r;
    logic [7:0] power_status_mask_r;
    logic [7:0] fault_status_mask_r;
    logic [7:0] port_control_r;
    logic [7:0] termination_role_control_r;
    logic [7:0] fault_detect_control_r;
    logic [7:0] power_path_control_r;
    logic [7:0] ovp_level_r;
    logic       ovp_flag_r;
    logic [7:0] alert_lo_r;
    logic [7:0] alert_hi_r;
    logic [7:0] vbus_s1_r;
    logic [7:0] vbus_s2_r;
    logic [7:0] vbus_s3_r;
    logic       hit_lo;
    logic       hit_hi;

    assign hit_lo = wr_en_in && addr_in == `TPAM_OFF_ALERT_LO;
    assign hit_hi = wr_en_in && addr_in == `TPAM_OFF_ALERT_HI;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            alert_mask_low_r           <= `TPAM_RST_MASK_LO;
            alert_mask_high_r          <= `TPAM_RST_MASK_HI; // RULE3
            power_status_mask_r        <= `TPAM_RST_PWR_MASK; // RULE4
            fault_status_mask_r        <= `TPAM_RST_FLT_MASK; // RULE5
            port_control_r             <= `TPAM_RST_PORT_CTL; // RULE6
            termination_role_control_r <= `TPAM_RST_ROLE_CTL; // RULE15
            fault_detect_control_r     <= `TPAM_RST_FLT_CTL;
            power_path_control_r       <= `TPAM_RST_PWR_CTL;
            ovp_level_r                <= `TPAM_RST_OVP_LEVEL;
        end else if (wr_en_in) begin
            case (addr_in)
                `TPAM_OFF_MASK_LO:   alert_mask_low_r <= wdata_in;
                `TPAM_OFF_MASK_HI:   alert_mask_high_r <= wdata_in & `TPAM_WMASK_MASK_HI; // RULE23
                `TPAM_OFF_PWR_MASK:  power_status_mask_r <= wdata_in;
                `TPAM_OFF_FLT_MASK:  fault_status_mask_r <= wdata_in;
                `TPAM_OFF_PORT_CTL:  port_control_r <= wdata_in & `TPAM_WMASK_PORT_CTL; // RULE8
                `TPAM_OFF_ROLE_CTL:  termination_role_control_r <= wdata_in & `TPAM_WMASK_ROLE_CTL;
                `TPAM_OFF_FLT_CTL:   fault_detect_control_r <= wdata_in & `TPAM_WMASK_FLT_CTL;
                `TPAM_OFF_PWR_CTL:   power_path_control_r <= wdata_in & `TPAM_WMASK_PWR_CTL;
                `TPAM_OFF_OVP_LEVEL: ovp_level_r <= wdata_in;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
        end else if (rd_en_in) begin
            case (addr_in)
                `TPAM_OFF_ALERT_LO:  rdata_out <= alert_lo_r;
                `TPAM_OFF_ALERT_HI:  rdata_out <= alert_hi_r;
                `TPAM_OFF_MASK_LO:   rdata_out <= alert_mask_low_r;
                `TPAM_OFF_MASK_HI:   rdata_out <= alert_mask_high_r;
                `TPAM_OFF_PWR_MASK:  rdata_out <= power_status_mask_r;
                `TPAM_OFF_FLT_MASK:  rdata_out <= fault_status_mask_r;
                `TPAM_OFF_PORT_CTL:  rdata_out <= port_control_r;
                `TPAM_OFF_ROLE_CTL:  rdata_out <= termination_role_control_r;
                `TPAM_OFF_FLT_CTL:   rdata_out <= fault_detect_control_r;
                `TPAM_OFF_PWR_CTL:   rdata_out <= power_path_control_r;
                `TPAM_OFF_OVP_LEVEL: rdata_out <= ovp_level_r;
                `TPAM_OFF_OVP_STAT:  rdata_out <= {6'h00, ovp_flag_r, 1'b0};
                default:             rdata_out <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky alert events; a new event in the clearing cycle survives.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            alert_lo_r <= `TPAM_RST_ALERT;
            alert_hi_r <= `TPAM_RST_ALERT;
        end else begin
            alert_lo_r <= (alert_lo_r & ~(hit_lo ? wdata_in : 8'h00)) | alert_lo_in; // RULE21
            alert_hi_r <= ((alert_hi_r & ~(hit_hi ? wdata_in : 8'h00)) | alert_hi_in)
                          & `TPAM_WMASK_MASK_HI; // RULE21
        end
    end

    // Power status and fault events feed the interrupt through their own masks and bit 1 of the low and high alert masks, not the alert event bits.
    logic any_pwr;
    logic any_flt;
    logic any_alert;
    assign any_pwr = |(pwr_status_in & power_status_mask_r); // RULE1
    assign any_flt = |(fault_status_in & fault_status_mask_r); // RULE1
    assign any_alert = |(alert_lo_r & alert_mask_low_r) | |(alert_hi_r & alert_mask_high_r)
                       | (any_pwr & alert_mask_low_r[`TPAM_BIT_SUM])
                       | (any_flt & alert_mask_high_r[`TPAM_BIT_SUM]);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_n_out          <= 1'b1;
            alert_lo_event_out <= 8'h00;
            alert_hi_event_out <= 8'h00;
        end else begin
            irq_n_out          <= ~any_alert; // RULE2 RULE20 RULE22
            alert_lo_event_out <= alert_lo_r;
            alert_hi_event_out <= alert_hi_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port, power path and fault control decode.
    logic orient;
    logic vconn_en;
    assign orient   = port_control_r[`TPAM_BIT_ORIENT];
    assign vconn_en = power_path_control_r[`TPAM_BIT_VCONN_EN];

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_msg_report_out           <= 1'b0;
            goodcrc_ack_out             <= 1'b0;
            watchdog_en_out             <= 1'b0;
            dbg_accessory_flag_out      <= 1'b0;
            vconn_cc1_out               <= 1'b0;
            vconn_cc2_out               <= 1'b0;
            rx_on_cc2_out               <= 1'b0;
            discharge_fail_timer_en_out <= 1'b1;
            vconn_oc_detect_en_out      <= 1'b1;
            scl_hold_out                <= 1'b0;
        end else begin
            goodcrc_ack_out   <= rx_msg_in; // RULE9
            rx_msg_report_out <= rx_msg_in & ~port_control_r[`TPAM_BIT_TEST]; // RULE9
            watchdog_en_out   <= port_control_r[`TPAM_BIT_WDOG]; // RULE6
            if (!port_control_r[`TPAM_BIT_DBG_OWNER]) begin
                dbg_accessory_flag_out <= dbg_accessory_dev_in; // RULE7
            end
            vconn_cc1_out <= vconn_en & orient; // RULE11
            vconn_cc2_out <= vconn_en & ~orient; // RULE11
            rx_on_cc2_out <= orient; // RULE11
            discharge_fail_timer_en_out <=
                ~fault_detect_control_r[`TPAM_BIT_DISC_TMR_OFF]; // RULE16
            vconn_oc_detect_en_out <= ~fault_detect_control_r[`TPAM_BIT_VCONN_OC_DIS]; // RULE17
            scl_hold_out <= 1'b0; // RULE8 RULE18
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Overvoltage comparator on a synchronised level sample.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            vbus_s1_r     <= 8'h00;
            vbus_s2_r     <= 8'h00;
            vbus_s3_r     <= 8'h00;
            ovp_flag_r    <= 1'b0;
            fault_pin_out <= 1'b0;
        end else begin
            vbus_s1_r <= vbus_level_in;
            vbus_s2_r <= vbus_s1_r;
            vbus_s3_r <= vbus_s2_r;
            if (vbus_s2_r == vbus_s3_r && vbus_s3_r > ovp_level_r) begin
                ovp_flag_r    <= 1'b1; // RULE19
                fault_pin_out <= 1'b1; // RULE19
            end else if (wr_en_in && addr_in == `TPAM_OFF_OVP_STAT
                         && wdata_in[`TPAM_BIT_OVP_FLAG]) begin
                ovp_flag_r    <= 1'b0;
                fault_pin_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Termination control and dual-role toggling.
    tpam_pkg::tpam_tgl_t tgl_r;
    logic [15:0]         tgl_cnt_r;
    logic                tgl_phase_r;
    logic                settled_sink_r;
    logic                dual_role_toggle;
    assign dual_role_toggle = termination_role_control_r[`TPAM_BIT_DRP];

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tgl_r          <= tpam_pkg::TPAM_TGL_IDLE;
            tgl_cnt_r      <= 16'h0000;
            tgl_phase_r    <= 1'b0;
            settled_sink_r <= 1'b0;
        end else begin
            case (tgl_r)
                tpam_pkg::TPAM_TGL_IDLE: begin
                    if (dual_role_toggle && seek_attach_command_in) begin
                        tgl_r     <= tpam_pkg::TPAM_TGL_PHASE; // RULE12
                        tgl_cnt_r <= 16'h0000;
                    end
                end
                tpam_pkg::TPAM_TGL_PHASE: begin
                    if (!dual_role_toggle) begin
                        tgl_r <= tpam_pkg::TPAM_TGL_IDLE; // RULE13
                    end else if (attach_seen_in) begin
                        tgl_r          <= tpam_pkg::TPAM_TGL_SETTLE; // RULE12
                        settled_sink_r <= attach_as_sink_in;
                    end else if (tgl_cnt_r == 16'(TOGGLE_CYCLES - 1)) begin
                        tgl_cnt_r   <= 16'h0000;
                        tgl_phase_r <= ~tgl_phase_r;
                    end else begin
                        tgl_cnt_r <= tgl_cnt_r + 16'h0001;
                    end
                end
                tpam_pkg::TPAM_TGL_SETTLE: begin
                    if (!dual_role_toggle || seek_attach_command_in) begin
                        tgl_r <= dual_role_toggle ? tpam_pkg::TPAM_TGL_PHASE : tpam_pkg::TPAM_TGL_IDLE;
                    end
                end
                default: tgl_r <= tpam_pkg::TPAM_TGL_IDLE;
            endcase
        end
    end

    logic [1:0] tgl_term;
    assign tgl_term = (tgl_r == tpam_pkg::TPAM_TGL_SETTLE)
                      ? (settled_sink_r ? `TPAM_TERM_RD : `TPAM_TERM_RP)
                      : (tgl_phase_r ? `TPAM_TERM_RD : `TPAM_TERM_RP);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cc1_term_out             <= `TPAM_TERM_RD;
            cc2_term_out             <= `TPAM_TERM_RD;
            pullup_current_level_out <= 2'h0;
            seek_active_out          <= 1'b0;
        end else begin
            if (tgl_r == tpam_pkg::TPAM_TGL_IDLE) begin
                cc1_term_out <= termination_role_control_r[1:0]; // RULE13 RULE15
                cc2_term_out <= termination_role_control_r[3:2]; // RULE13 RULE15
            end else begin
                cc1_term_out <= tgl_term; // RULE12
                cc2_term_out <= tgl_term; // RULE12
            end
            if (termination_role_control_r[5:4] != `TPAM_RP_RESERVED) begin
                pullup_current_level_out <= termination_role_control_r[5:4]; // RULE14
            end
            seek_active_out <= (tgl_r == tpam_pkg::TPAM_TGL_PHASE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    mask_block_a: assert property (@(posedge clk_in) disable iff (reset_in) // RULE2
        (alert_mask_low_r == 8'h00 && alert_mask_high_r == 8'h00) |=> irq_n_out)
        else $error("masked events pulled interrupt low");
    irq_follow_a: assert property (@(posedge clk_in) disable iff (reset_in) // RULE20
        (!reset_in && |(alert_lo_r & alert_mask_low_r)) |=> !irq_n_out)
        else $error("unmasked event did not pull interrupt low");
    sticky_event_a: assert property (@(posedge clk_in) disable iff (reset_in) // RULE21
        (alert_lo_r[0] && !(hit_lo && wdata_in[0])) |=> alert_lo_r[0])
        else $error("event bit lost without clear");
    test_mode_a: assert property (@(posedge clk_in) disable iff (reset_in) // RULE9
        (rx_msg_in && port_control_r[`TPAM_BIT_TEST])
        |=> (goodcrc_ack_out && !rx_msg_report_out))
        else $error("test mode reported or skipped ack");
    orient_route_a: assert property (@(posedge clk_in) disable iff (reset_in) // RULE11
        (power_path_control_r[`TPAM_BIT_VCONN_EN] && !port_control_r[`TPAM_BIT_ORIENT])
        |=> (vconn_cc2_out && !vconn_cc1_out))
        else $error("VCONN not routed to second line");
    role_follow_a: assert property (@(posedge clk_in) disable iff (reset_in) // RULE13
        (tgl_r == tpam_pkg::TPAM_TGL_IDLE)
        |=> cc1_term_out == $past(termination_role_control_r[1:0]))
        else $error("termination not following role");
    ovp_flag_a: assert property (@(posedge clk_in) disable iff (reset_in) // RULE19
        (vbus_s2_r == vbus_s3_r && vbus_s3_r > ovp_level_r)
        |=> (ovp_flag_r && fault_pin_out))
        else $error("overvoltage not flagged");
    rsvd_zero_a: assert property (@(posedge clk_in) disable iff (reset_in) // RULE23
        alert_mask_high_r[6:4] == 3'h0 && port_control_r[3:2] == 2'h0)
        else $error("reserved bits set");
    wdog_en_a: assert property (@(posedge clk_in) disable iff (reset_in) // RULE6
        ##1 watchdog_en_out == $past(port_control_r[`TPAM_BIT_WDOG]))
        else $error("watchdog enable mismatch");
    irq_seen_c: cover property (@(posedge clk_in) !irq_n_out);
    toggle_c: cover property (@(posedge clk_in) tgl_r == tpam_pkg::TPAM_TGL_SETTLE);
    ovp_c: cover property (@(posedge clk_in) fault_pin_out);
endmodule // tpam_regs
`default_nettype wire

/* tb/tpam_plug_model.sv */
// Far-side plug model that attaches once the port has been seeking for a while.
`timescale 1ns/1ns
`default_nettype none
module tpam_plug_model #(
    parameter int DELAY = 20
) (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic seek_active_in,
    input  wire logic sink_in,
    output logic      attach_seen_out,
    output logic      attach_as_sink_out
);
    int cnt_r;
    // The plug shows itself only after several toggle phases, so a toggle is seen first.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cnt_r <= 0;
        end else if (seek_active_in && cnt_r < DELAY) begin
            cnt_r <= cnt_r + 1;
        end
    end
    assign attach_seen_out    = (cnt_r >= DELAY);
    assign attach_as_sink_out = sink_in;
endmodule // tpam_plug_model
`default_nettype wire

/* tb/test_tpam_regs.sv */
// Self-checking bench of the port alert mask and control bank.
`timescale 1ns/1ns
`default_nettype none
module test_tpam_regs;
    logic        clk_in = 1'b0, reset_in = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic        rx = 1'b0, seek = 1'b0, dbg = 1'b0, sink = 1'b1;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, alo = 8'h00, ahi = 8'h00;
    logic [7:0]  pwr = 8'h00, flt = 8'h00, vbus = 8'h00;
    logic [7:0]  rdata, alo_ev, ahi_ev, got, d;
    logic [1:0]  cc1t, cc2t, rpl;
    logic        irq_n, rx_rep, gcrc, wdog, dbgf, vc1, vc2, rxcc2, seek_act;
    logic        tmr_en, oc_en, fpin, scl, attach, asink, seen_rp, seen_rd;
    logic [31:0] seed = 32'h5db56491;
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;
    logic [7:0]  offs [9] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'hcc};
    logic [7:0]  rst  [9] = '{8'hff, 8'h0f, 8'hff, 8'hff, 8'h00, 8'h0a, 8'h00, 8'h60, 8'hff};
    logic [7:0]  wm   [9] = '{8'hff, 8'h8f, 8'hff, 8'hff, 8'h33, 8'h7f, 8'h1f, 8'h7d, 8'hff};

    tpam_regs #(.TOGGLE_CYCLES(4)) i_tpam_regs (.clk_in(clk_in), .reset_in(reset_in),
        .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata),
        .rdata_out(rdata), .alert_lo_in(alo), .alert_hi_in(ahi), .pwr_status_in(pwr),
        .fault_status_in(flt), .rx_msg_in(rx), .seek_attach_command_in(seek),
        .attach_seen_in(attach), .attach_as_sink_in(asink), .dbg_accessory_dev_in(dbg),
        .vbus_level_in(vbus), .irq_n_out(irq_n), .alert_lo_event_out(alo_ev),
        .alert_hi_event_out(ahi_ev), .rx_msg_report_out(rx_rep), .goodcrc_ack_out(gcrc),
        .watchdog_en_out(wdog), .dbg_accessory_flag_out(dbgf), .vconn_cc1_out(vc1),
        .vconn_cc2_out(vc2), .rx_on_cc2_out(rxcc2), .cc1_term_out(cc1t),
        .cc2_term_out(cc2t), .pullup_current_level_out(rpl), .seek_active_out(seek_act),
        .discharge_fail_timer_en_out(tmr_en), .vconn_oc_detect_en_out(oc_en),
        .fault_pin_out(fpin), .scl_hold_out(scl));
    tpam_plug_model #(.DELAY(20)) i_tpam_plug_model (.clk_in(clk_in), .reset_in(reset_in),
        .seek_active_in(seek_act), .sink_in(sink), .attach_seen_out(attach),
        .attach_as_sink_out(asink));

    always #25 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: byte %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: bit %b, expected %b", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_in);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk_in);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd_en <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_in);
        reset_in <= 1'b0;
        settle(2);
        chk_bit(irq_n, 1'b0);
        chk_bit(wdog, 1'b0);
        for (int i = 0; i < 9; i++) begin
            rd(offs[i]);
            chk_byte(got, rst[i]);
        end
        rd(8'h30);
        chk_byte(got, 8'h00);
        for (int i = 0; i < 9; i++) begin
            d = 8'(rnd());
            if (offs[i] == 8'h1a) d = d & 8'h9f;
            wr(offs[i], d);
            rd(offs[i]);
            chk_byte(got, d & wm[i]);
        end
        wr(8'h10, 8'hff);
        wr(8'h11, 8'hff);
        settle(3);
        chk_bit(irq_n, 1'b1);
        wr(8'h13, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(8'h12, 8'h00);
            @(posedge clk_in);
            alo <= 8'h01 << k;
            @(posedge clk_in);
            alo <= 8'h00;
            settle(3);
            chk_bit(irq_n, 1'b1);
            chk_byte(alo_ev, 8'h01 << k);
            wr(8'h12, 8'h01 << k);
            settle(3);
            chk_bit(irq_n, 1'b0);
            wr(8'h10, 8'h01 << k);
            settle(3);
            chk_bit(irq_n, 1'b1);
        end
        wr(8'h13, 8'h0f);
        @(posedge clk_in);
        ahi <= 8'h80;
        @(posedge clk_in);
        ahi <= 8'h00;
        settle(3);
        chk_bit(irq_n, 1'b1);
        chk_byte(ahi_ev, 8'h80);
        wr(8'h13, 8'h8f);
        settle(3);
        chk_bit(irq_n, 1'b0);
        wr(8'h11, 8'h80);
        wr(8'h12, 8'h02);
        wr(8'h14, 8'h00);
        wr(8'h15, 8'h00);
        pwr <= 8'h04;
        flt <= 8'h02;
        settle(5);
        chk_bit(irq_n, 1'b1);
        wr(8'h15, 8'h02);
        settle(3);
        chk_bit(irq_n, 1'b0);
        pwr <= 8'h00;
        flt <= 8'h00;
        wr(8'h1c, 8'h61);
        for (int o = 0; o < 2; o++) begin
            wr(8'h19, 8'(o));
            settle(3);
            chk_byte({5'h00, vc1, vc2, rxcc2}, o ? 8'h05 : 8'h02);
        end
        wr(8'h19, 8'h2c);
        settle(3);
        chk_bit(wdog, 1'b1);
        chk_bit(scl, 1'b0);
        for (int t = 0; t < 2; t++) begin
            wr(8'h19, t ? 8'h02 : 8'h00);
            settle(2);
            @(posedge clk_in);
            rx <= 1'b1;
            @(posedge clk_in);
            rx <= 1'b0;
            #1 chk_bit(gcrc, 1'b1);
            chk_bit(rx_rep, t == 0);
        end
        wr(8'h19, 8'h00);
        for (int v = 0; v < 2; v++) begin
            wr(8'h19, v ? 8'h10 : 8'h00);
            dbg <= 1'b1;
            settle(4);
            chk_bit(dbgf, v == 0);
            dbg <= 1'b0;
            settle(4);
            chk_bit(dbgf, 1'b0);
        end
        for (int r = 0; r < 3; r++) begin
            d = 8'(rnd()) & 8'h0f;
            wr(8'h1a, d | 8'(r << 4));
            settle(3);
            chk_byte({4'h0, cc2t, cc1t}, d);
            chk_byte({6'h00, rpl}, 8'(r));
        end
        wr(8'h1a, 8'h3a);
        settle(3);
        chk_byte({6'h00, rpl}, 8'h02);
        for (int v = 0; v < 2; v++) begin
            wr(8'h1b, (v ? 8'h09 : 8'h00) | (8'(rnd()) & 8'h14));
            settle(3);
            chk_byte({6'h00, tmr_en, oc_en}, v ? 8'h00 : 8'h03);
        end
        wr(8'hcc, 8'h80);
        vbus <= 8'h81;
        settle(8);
        chk_bit(fpin, 1'b1);
        rd(8'hcd);
        chk_byte(got & 8'h02, 8'h02);
        vbus <= 8'h10;
        settle(6);
        wr(8'hcd, 8'h02);
        rd(8'hcd);
        chk_byte(got & 8'h02, 8'h00);
        chk_bit(fpin, 1'b0);
        wr(8'h1a, 8'h4a);
        @(posedge clk_in);
        seek <= 1'b1;
        @(posedge clk_in);
        seek <= 1'b0;
        settle(2);
        chk_bit(seek_act, 1'b1);
        seen_rp = 1'b0;
        seen_rd = 1'b0;
        repeat (100) begin
            settle(1);
            if (cc1t === 2'h1) seen_rp = 1'b1;
            if (cc1t === 2'h2) seen_rd = 1'b1;
        end
        chk_bit(seen_rp & seen_rd, 1'b1);
        chk_bit(seek_act, 1'b0);
        chk_byte({6'h00, cc1t}, 8'h02);
        print_verdict();
    end
endmodule // test_tpam_regs
`default_nettype wire
